// ### hwcfg_cfg.svh
// offsets, field positions, reset values and timing counts of the hardware configuration word
`ifndef HWCFG_CFG_SVH
`define HWCFG_CFG_SVH

// register placement on the bus
`define HWCFG_ADDR 12'h014
`define HWCFG_SIZE_WORD 3'h2

// field positions
`define HWCFG_BIT_FULL 0
`define HWCFG_BIT_BURST 1
`define HWCFG_BIT_PHYSEL 2
`define HWCFG_BIT_LITE 3
`define HWCFG_BIT_EESHORT 4
`define HWCFG_BIT_MULTI 5
`define HWCFG_BIT_DROP 6
`define HWCFG_BIT_MIIVIS 7
`define HWCFG_BIT_NOSTALL 8
`define HWCFG_RXOFF_LSB 9
`define HWCFG_RXOFF_MSB 10
`define HWCFG_BOOST_LSB 13
`define HWCFG_BOOST_MSB 14
`define HWCFG_BIT_DETACH 18

// reset values
`define HWCFG_RST_RXOFF 2'h0
`define HWCFG_RST_BOOST 2'h0
`define HWCFG_RST_BIT 1'h0

// timing
`define HWCFG_CLK_NS 8
`define HWCFG_EE_LONG_MS 30
`define HWCFG_EE_SHORT_NS 1280
`define HWCFG_EE_LONG_CYC ((`HWCFG_EE_LONG_MS * 1000000 + `HWCFG_CLK_NS - 1) / `HWCFG_CLK_NS)
`define HWCFG_EE_SHORT_CYC ((`HWCFG_EE_SHORT_NS + `HWCFG_CLK_NS - 1) / `HWCFG_CLK_NS)
`define HWCFG_EE_CNT_W 22
`define HWCFG_RST_HOLD_NS 1000
`define HWCFG_RST_HOLD_CYC ((`HWCFG_RST_HOLD_NS + `HWCFG_CLK_NS - 1) / `HWCFG_CLK_NS)

`endif

// ### hwcfg_host.sv
// host-side bus model that reaches the hardware configuration word
`timescale 1ns/1ns

module hwcfg_host (
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // bus parked idle until a transfer is asked for
    initial begin
        hsel <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one word transfer; read data returned in q at the end of the data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        hwdata <= ~hwdata; // released data lines keep changing, no stale value
        // address phase held until the slave is ready
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        // data phase held until ready, read data taken at that edge
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // hwcfg_host

// ### hwcfg_pkg.sv
// types shared by the hardware configuration register and its reset sequencer
package hwcfg_pkg;

    // writable fields of the configuration word
    typedef struct packed {
        logic [1:0] boost;
        logic [1:0] rx_off;
        logic no_stall;
        logic mii_vis;
        logic drop_err;
        logic multi;
        logic ee_short;
        logic burst_en;
    } hwcfg_fields_t;

    // captured bus address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
    } hwcfg_aph_t;

    // reset controls driven to the rest of the device
    typedef struct packed {
        logic datapath_rst;
        logic core_rst;
        logic ext_phy_rst_n;
        logic usb_phy_disc;
        logic ee_reload;
    } hwcfg_rstctl_t;

    // reset sequencer states
    typedef enum logic [3:0] {
        HWCFG_RS_IDLE = 4'h1,
        HWCFG_RS_LITE = 4'h2,
        HWCFG_RS_FULL = 4'h4,
        HWCFG_RS_LOAD = 4'h8
    } hwcfg_rs_t;

endpackage

// ### hwcfg_regs.sv
// hardware configuration register, low control fields, on an ahb-lite slave port
//
// Functional notes
// - rx offset field shifts receive data 0-3
// - sync loss stalls bulk-out unless no-stall set
// - internal phy visibility drives mii pins out
// - visibility ignored with external phy
// - visibility overrides gpio mode of mii pins
// - drop bit discards errored received frames
// - multi-frame bit allows packing transmit frames
// - usb receive always accepts several frames
// - eeprom timeout 30 ms or 1.28 us
// - lite reset bit starts sequence, self-clears
// - lite reset spares usb core, eeprom, phy
// - phy select reads strap, read-only
// - burst enable applies burst cap limit
// - full reset resets device and external phy
// - full reset reloads eeprom, disconnects, reconnects
// - usb or lite reset restores drive boost
// - detach flag set at reset after event
// - 32-bit register at offset 014h
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`include "hwcfg_cfg.svh"

module hwcfg_regs import hwcfg_pkg::*; #(
    parameter int EE_LONG_CYC = `HWCFG_EE_LONG_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic phy_choice_strap,
    input wire logic detach_event_in,
    input wire logic usb_bus_reset,
    input wire logic tx_sync_lost,
    input wire logic rx_frame_done,
    input wire logic rx_frame_bad,
    input wire logic [7:0] gpio_cfg_mode,
    input wire logic ee_waiting,
    input wire logic ee_present,
    input wire logic ee_load_done,
    input wire logic [1:0] ee_boost_image,
    output logic [1:0] rx_payload_offset,
    output logic bulk_out_stall,
    output logic mii_grp_oe_n,
    output logic [7:0] pin_gpio_mode,
    output logic rx_frame_keep,
    output logic rx_frame_drop,
    output logic usb_tx_multi_frame,
    output logic usb_rx_multi_frame,
    output logic tx_burst_cap_on,
    output logic ee_timeout,
    output logic [1:0] hs_drive_boost,
    output logic datapath_rst,
    output logic core_rst,
    output logic ext_phy_rst_n,
    output logic usb_phy_disc,
    output logic ee_reload
);

    localparam logic [21:0] EE_SHORT_LIM = 22'(`HWCFG_EE_SHORT_CYC);
    localparam int EE_SHORT_A = `HWCFG_EE_SHORT_CYC;
    localparam logic [11:0] REG_ADDR = `HWCFG_ADDR; // byte address of the word
    localparam hwcfg_fields_t FIELDS_RST = '{
        boost: `HWCFG_RST_BOOST, rx_off: `HWCFG_RST_RXOFF, no_stall: `HWCFG_RST_BIT,
        mii_vis: `HWCFG_RST_BIT, drop_err: `HWCFG_RST_BIT, multi: `HWCFG_RST_BIT,
        ee_short: `HWCFG_RST_BIT, burst_en: `HWCFG_RST_BIT};

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // word-sized access to the one register
    function automatic logic reg_hit(input logic [31:0] a, input logic [2:0] s);
        reg_hit = (a[11:2] == REG_ADDR[11:2]) && (s == `HWCFG_SIZE_WORD);
    endfunction

    // assemble the read word; reserved bits read zero
    function automatic logic [31:0] hw_word(input hwcfg_fields_t f, input logic det,
            input logic ps, input logic lb, input logic fb);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`HWCFG_BIT_DETACH] = det;
        w[`HWCFG_BOOST_MSB:`HWCFG_BOOST_LSB] = f.boost;
        w[`HWCFG_RXOFF_MSB:`HWCFG_RXOFF_LSB] = f.rx_off;
        w[`HWCFG_BIT_NOSTALL] = f.no_stall;
        w[`HWCFG_BIT_MIIVIS] = f.mii_vis;
        w[`HWCFG_BIT_DROP] = f.drop_err;
        w[`HWCFG_BIT_MULTI] = f.multi;
        w[`HWCFG_BIT_EESHORT] = f.ee_short;
        w[`HWCFG_BIT_LITE] = lb;
        w[`HWCFG_BIT_PHYSEL] = ps;
        w[`HWCFG_BIT_BURST] = f.burst_en;
        w[`HWCFG_BIT_FULL] = fb;
        hw_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    hwcfg_aph_t aph_q, aph_d; // pending data phase
    logic [31:0] hrdata_q, hrdata_d; // read data
    hwcfg_fields_t fields_q, fields_d; // writable fields
    logic [1:0] img_q, img_d; // boost value last loaded from eeprom
    logic init_q, init_d; // strap and detach captured
    logic phy_choice_strap_q, phy_choice_strap_d; // 1 = external phy
    logic detach_q, detach_d; // detach event seen
    logic stall_q, stall_d; // bulk-out pipe stalled
    logic oe_n_q, oe_n_d; // mii group output enable, low drives
    logic [7:0] gmode_q, gmode_d; // gpio mode passed to pins
    logic keep_q, keep_d; // frame pass pulse
    logic drop_q, drop_d; // frame discard pulse
    logic multi_q, multi_d; // transmit packing allowed
    logic burst_q, burst_d; // burst cap in force
    logic [21:0] ee_cnt_q, ee_cnt_d; // cycles waited on eeprom
    logic ee_to_q, ee_to_d; // timeout pulse
    logic wr_en; // register write in data phase
    logic seq_idle; // no reset sequence running
    logic start_lite, start_full; // sequence starts
    logic mii_drive; // internal phy with visible mii
    logic [21:0] ee_lim; // selected timeout length
    logic lite_busy, full_busy; // sequencer status
    hwcfg_rstctl_t rstctl; // sequencer controls

    ////////////////////////////////////////////////////////////////////////////////
    // reset sequencer
    hwcfg_rstseq u_rstseq (
        .mclk(mclk),
        .nrst(nrst),
        .start_lite(start_lite),
        .start_full(start_full),
        .ee_done(ee_load_done | ee_to_q),
        .lite_busy(lite_busy),
        .full_busy(full_busy),
        .ctl(rstctl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next values
    always_comb begin
        // bus address phase capture
        aph_d.valid = hsel && htrans[1] && hready;
        aph_d.write = hwrite;
        aph_d.hit = reg_hit(haddr, hsize);
        wr_en = aph_q.valid && aph_q.write && aph_q.hit;
        // starts only on a written 1 and only when idle; zeros do nothing
        seq_idle = !lite_busy && !full_busy;
        start_full = wr_en && hwdata[`HWCFG_BIT_FULL] && seq_idle;
        start_lite = wr_en && hwdata[`HWCFG_BIT_LITE] && seq_idle
            && !hwdata[`HWCFG_BIT_FULL];

        // writable fields
        fields_d = fields_q;
        if (wr_en) begin
            fields_d.boost = hwdata[`HWCFG_BOOST_MSB:`HWCFG_BOOST_LSB];
            fields_d.rx_off = hwdata[`HWCFG_RXOFF_MSB:`HWCFG_RXOFF_LSB];
            fields_d.no_stall = hwdata[`HWCFG_BIT_NOSTALL];
            fields_d.mii_vis = hwdata[`HWCFG_BIT_MIIVIS];
            fields_d.drop_err = hwdata[`HWCFG_BIT_DROP];
            fields_d.multi = hwdata[`HWCFG_BIT_MULTI];
            fields_d.ee_short = hwdata[`HWCFG_BIT_EESHORT];
            fields_d.burst_en = hwdata[`HWCFG_BIT_BURST];
        end
        // full reset returns every field to default except boost, which takes the loaded image
        if (start_full) begin
            fields_d = FIELDS_RST;
            fields_d.boost = img_q;
        end
        // usb bus reset or lite reset restores the loaded boost
        if (usb_bus_reset || start_lite) begin
            fields_d.boost = img_q;
        end
        // a fresh eeprom load sets both image and field
        img_d = img_q;
        if (ee_load_done) begin
            img_d = ee_present ? ee_boost_image : `HWCFG_RST_BOOST;
            fields_d.boost = img_d;
        end

        // strap and detach event taken once after reset release
        init_d = 1'b1;
        phy_choice_strap_d = init_q ? phy_choice_strap_q : phy_choice_strap;
        detach_d = init_q ? detach_q : detach_event_in;
        if (init_q && wr_en && hwdata[`HWCFG_BIT_DETACH]) begin
            detach_d = 1'b0; // write one to clear
        end

        // stall: a new loss of sync beats the reset clear
        stall_d = (stall_q && !rstctl.datapath_rst)
            || (tx_sync_lost && !fields_q.no_stall);

        // pin direction and gpio override
        mii_drive = !phy_choice_strap_q && fields_q.mii_vis;
        oe_n_d = !mii_drive;
        gmode_d = mii_drive ? 8'h00 : gpio_cfg_mode;

        // receive frame disposal
        keep_d = rx_frame_done && !(rx_frame_bad && fields_q.drop_err);
        drop_d = rx_frame_done && rx_frame_bad && fields_q.drop_err;

        // transmit packing and burst limit
        multi_d = fields_q.multi;
        burst_d = fields_q.burst_en;

        // eeprom timeout counter, saturates so the pulse fires once per wait
        ee_lim = fields_q.ee_short ? EE_SHORT_LIM : 22'(EE_LONG_CYC);
        ee_cnt_d = 22'h00_0000;
        if (ee_waiting) begin
            ee_cnt_d = (ee_cnt_q >= ee_lim) ? ee_cnt_q : ee_cnt_q + 22'h00_0001;
        end
        ee_to_d = ee_waiting && (ee_cnt_q == ee_lim - 22'h00_0001);

        // read data built from next values so a write just done is seen
        hrdata_d = 32'h0000_0000;
        if (aph_d.valid && !hwrite && aph_d.hit) begin
            hrdata_d = hw_word(fields_d, detach_d, phy_choice_strap_d, lite_busy || start_lite,
                full_busy || start_full);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aph_q <= '0;
            hrdata_q <= 32'h0000_0000;
            fields_q <= FIELDS_RST;
            img_q <= `HWCFG_RST_BOOST;
            init_q <= 1'b0;
            phy_choice_strap_q <= 1'b0;
            detach_q <= 1'b0;
            stall_q <= 1'b0;
            oe_n_q <= 1'b1;
            gmode_q <= 8'h00;
            keep_q <= 1'b0;
            drop_q <= 1'b0;
            multi_q <= 1'b0;
            burst_q <= 1'b0;
            ee_cnt_q <= 22'h00_0000;
            ee_to_q <= 1'b0;
        end else begin
            aph_q <= aph_d;
            hrdata_q <= hrdata_d;
            fields_q <= fields_d;
            img_q <= img_d;
            init_q <= init_d;
            phy_choice_strap_q <= phy_choice_strap_d;
            detach_q <= detach_d;
            stall_q <= stall_d;
            oe_n_q <= oe_n_d;
            gmode_q <= gmode_d;
            keep_q <= keep_d;
            drop_q <= drop_d;
            multi_q <= multi_d;
            burst_q <= burst_d;
            ee_cnt_q <= ee_cnt_d;
            ee_to_q <= ee_to_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; slave never waits and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign rx_payload_offset = fields_q.rx_off;
    assign bulk_out_stall = stall_q;
    assign mii_grp_oe_n = oe_n_q;
    assign pin_gpio_mode = gmode_q;
    assign rx_frame_keep = keep_q;
    assign rx_frame_drop = drop_q;
    assign usb_tx_multi_frame = multi_q;
    assign usb_rx_multi_frame = 1'b1;
    assign tx_burst_cap_on = burst_q;
    assign ee_timeout = ee_to_q;
    assign hs_drive_boost = fields_q.boost;
    assign datapath_rst = rstctl.datapath_rst;
    assign core_rst = rstctl.core_rst;
    assign ext_phy_rst_n = rstctl.ext_phy_rst_n;
    assign usb_phy_disc = rstctl.usb_phy_disc;
    assign ee_reload = rstctl.ee_reload;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    AST_STALL_ON_LOSS: assert property (@(posedge mclk) disable iff (!nrst)
        tx_sync_lost && !fields_q.no_stall |=> bulk_out_stall)
        else $error("sync loss did not stall bulk-out");
    AST_STALL_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(bulk_out_stall) |-> $past(tx_sync_lost) && !$past(fields_q.no_stall))
        else $error("bulk-out stalled without cause");
    AST_EXT_PHY_IN: assert property (@(posedge mclk) disable iff (!nrst)
        init_q && phy_choice_strap_q |=> mii_grp_oe_n)
        else $error("mii pins driven with external phy");
    AST_MII_DRIVE: assert property (@(posedge mclk) disable iff (!nrst)
        init_q && !phy_choice_strap_q && fields_q.mii_vis |=> !mii_grp_oe_n)
        else $error("mii pins not driven when visible");
    AST_GPIO_LOCK: assert property (@(posedge mclk) disable iff (!nrst)
        !mii_grp_oe_n |-> pin_gpio_mode == 8'h00)
        else $error("gpio mode reached mii pins");
    AST_DROP: assert property (@(posedge mclk) disable iff (!nrst)
        rx_frame_done && rx_frame_bad && fields_q.drop_err |=> rx_frame_drop && !rx_frame_keep)
        else $error("errored frame not discarded");
    AST_EE_SHORT: assert property (@(posedge mclk) disable iff (!nrst)
        ee_timeout && $past(fields_q.ee_short) |-> $past(ee_waiting, EE_SHORT_A))
        else $error("short eeprom timeout fired early");
    AST_STRAP: assert property (@(posedge mclk) disable iff (!nrst)
        init_q && !$past(init_q) |-> phy_choice_strap_q == $past(phy_choice_strap))
        else $error("phy select not taken from strap");
    AST_BOOST_RESTORE: assert property (@(posedge mclk) disable iff (!nrst)
        usb_bus_reset && !ee_load_done |=> hs_drive_boost == $past(img_q))
        else $error("drive boost not restored");
    AST_READ_SEL: assert property (@(posedge mclk) disable iff (!nrst)
        aph_q.valid && !aph_q.write && aph_q.hit && $stable(phy_choice_strap_q)
        |-> hrdata[`HWCFG_BIT_PHYSEL] == phy_choice_strap_q)
        else $error("register read lost phy select");

endmodule // hwcfg_regs

// ### hwcfg_rstseq.sv
// soft reset sequencer: lite and full reset sequences
`timescale 1ns/1ns
`include "hwcfg_cfg.svh"

module hwcfg_rstseq import hwcfg_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start_lite,
    input wire logic start_full,
    input wire logic ee_done,
    output logic lite_busy,
    output logic full_busy,
    output hwcfg_rstctl_t ctl
);

    localparam logic [7:0] HOLD_CYC = 8'(`HWCFG_RST_HOLD_CYC);

    hwcfg_rs_t state_q, state_d; // sequence state
    logic [7:0] cnt_q, cnt_d; // hold counter
    logic reload_q, reload_d; // one-cycle reload request

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        reload_d = 1'b0;
        unique case (state_q)
            HWCFG_RS_IDLE: begin
                // full wins when both arrive together
                if (start_full) begin
                    state_d = HWCFG_RS_FULL;
                    cnt_d = 8'h00;
                end else if (start_lite) begin
                    state_d = HWCFG_RS_LITE;
                    cnt_d = 8'h00;
                end
            end
            HWCFG_RS_LITE: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == HOLD_CYC - 8'h01) begin
                    state_d = HWCFG_RS_IDLE;
                end
            end
            HWCFG_RS_FULL: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == HOLD_CYC - 8'h01) begin
                    state_d = HWCFG_RS_LOAD;
                    reload_d = 1'b1;
                end
            end
            HWCFG_RS_LOAD: begin
                // stay disconnected until the image is back
                if (ee_done) begin
                    state_d = HWCFG_RS_IDLE;
                end
            end
            default: begin
                state_d = HWCFG_RS_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= HWCFG_RS_IDLE;
            cnt_q <= 8'h00;
            reload_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            reload_q <= reload_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded controls; lite touches only the data path
    assign lite_busy = (state_q == HWCFG_RS_LITE);
    assign full_busy = (state_q == HWCFG_RS_FULL) || (state_q == HWCFG_RS_LOAD);
    assign ctl.datapath_rst = (state_q != HWCFG_RS_IDLE);
    assign ctl.core_rst = (state_q == HWCFG_RS_FULL);
    assign ctl.ext_phy_rst_n = (state_q != HWCFG_RS_FULL);
    assign ctl.usb_phy_disc = full_busy;
    assign ctl.ee_reload = reload_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    AST_LITE_SELF_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
        (state_q == HWCFG_RS_IDLE) && start_lite && !start_full
        |=> lite_busy ##[1:200] !lite_busy)
        else $error("lite reset bit did not clear");
    AST_LITE_KEEPS_USB: assert property (@(posedge mclk) disable iff (!nrst)
        lite_busy |-> !ctl.core_rst && !ctl.usb_phy_disc && !ctl.ee_reload)
        else $error("lite reset touched usb core or eeprom");
    AST_FULL_DISC: assert property (@(posedge mclk) disable iff (!nrst)
        (state_q == HWCFG_RS_IDLE) && start_full
        |=> (ctl.usb_phy_disc && !ctl.ext_phy_rst_n) [*8])
        else $error("full reset did not disconnect and reset phy");

endmodule // hwcfg_rstseq

// ### tb_hw_config_low_fields.sv
// self-checking bench for the hardware configuration word
`timescale 1ns/1ns

module tb_hw_config_low_fields import hwcfg_pkg::*;;
    logic mclk = 1'b0, nrst = 1'b0; // clock and active-low reset
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic strap = 1'b1, det = 1'b1, fr_bad = 1'b0, ee_wait = 1'b0, ee_pres = 1'b0;
    logic usb_rst = 1'b0, sync_lost = 1'b0, fr_done = 1'b0, ee_done = 1'b0;
    logic [7:0] gpio = 8'hA5; // gpio mode request
    logic [1:0] img = 2'h0; // eeprom boost image
    logic [1:0] rx_off, boost;
    logic stall, oe_n, keep, drop, txm, rxm, bcap, eto, dp_rst, c_rst, ephy_n, disc, reload;
    logic [7:0] pmode;
    logic [31:0] q, e;
    int n_mismatch = 0, cmp_count = 0, n;
    // table rows: address, write data, expected word at 0x014
    logic [31:0] ra[7] = '{32'h14, 32'h14, 32'h14, 32'h14, 32'h18, 32'h14, 32'h14};
    logic [31:0] rw[7] = '{32'hFFFFF9F6, 32'h200, 32'h400, 32'h6A0, 32'h7F2, 32'h90, 32'h0};
    logic [31:0] re[7] = '{32'h61F2, 32'h200, 32'h400, 32'h6A0, 32'h6A0, 32'h90, 32'h0};

    always #4 mclk = ~mclk;

    hwcfg_host u_hwcfg_host (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // small timeout count keeps the no-response case short
    hwcfg_regs #(.EE_LONG_CYC(400)) u_hwcfg_regs (.mclk(mclk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .phy_choice_strap(strap), .detach_event_in(det), .usb_bus_reset(usb_rst),
        .tx_sync_lost(sync_lost), .rx_frame_done(fr_done), .rx_frame_bad(fr_bad),
        .gpio_cfg_mode(gpio), .ee_waiting(ee_wait), .ee_present(ee_pres),
        .ee_load_done(ee_done), .ee_boost_image(img), .rx_payload_offset(rx_off),
        .bulk_out_stall(stall), .mii_grp_oe_n(oe_n), .pin_gpio_mode(pmode),
        .rx_frame_keep(keep), .rx_frame_drop(drop), .usb_tx_multi_frame(txm),
        .usb_rx_multi_frame(rxm), .tx_burst_cap_on(bcap), .ee_timeout(eto),
        .hs_drive_boost(boost), .datapath_rst(dp_rst), .core_rst(c_rst),
        .ext_phy_rst_n(ephy_n), .usb_phy_disc(disc), .ee_reload(reload));

    ////////////////////////////////////////////////////////////////////////////////
    // compare one result, count it
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        u_hwcfg_host.xfer(1'b1, a, d, q);
    endtask
    task rd(input logic [31:0] a);
        u_hwcfg_host.xfer(1'b0, a, 32'h0, q);
    endtask
    // one-cycle pulse on {usb_rst, sync_lost, fr_done, ee_done}, settles after
    task pls(input logic [3:0] m);
        @(posedge mclk);
        {usb_rst, sync_lost, fr_done, ee_done} <= m;
        @(posedge mclk);
        {usb_rst, sync_lost, fr_done, ee_done} <= 4'h0;
        #1;
    endtask
    // hold reset six cycles with given strap and detach levels
    task rst_dut(input logic s, input logic d);
        strap <= s;
        det <= d;
        nrst <= 1'b0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
    endtask
    // bounded wait on a flag, cycles waited in n
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask
    task complete_run;
        $display("mismatches %0d of %0d checks", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog, far past the expected run of about a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        // external phy: strap and detach shown, visibility inert
        rst_dut(1'b1, 1'b1);
        rd(32'h14);
        chk(q, 32'h40004);
        chk(32'(rxm), 32'h1);
        chk(32'(hresp), 32'h0);
        // detach flag cleared by a written one
        wr(32'h14, 32'h40080);
        rd(32'h14);
        chk(q, 32'h84);
        chk(32'({oe_n, pmode}), 32'({1'b1, gpio}));
        // internal phy from here on
        rst_dut(1'b0, 1'b0);
        rd(32'h14);
        chk(q, 32'h0);
        // field table, unmapped write among the rows
        for (int i = 0; i < 7; i++) begin
            wr(ra[i], rw[i]);
            rd(32'h14);
            e = re[i];
            chk(q, e);
            chk(32'(rx_off), 32'(e[10:9]));
            chk(32'({txm, bcap}), 32'({e[5], e[1]}));
            chk(32'({oe_n, pmode}), 32'({~e[7], e[7] ? 8'h00 : gpio}));
        end
        rd(32'h18);
        chk(q, 32'h0);
        // sync loss with and without stall inhibit
        wr(32'h14, 32'h100);
        pls(4'h4);
        chk(32'(stall), 32'h0);
        wr(32'h14, 32'h0);
        pls(4'h4);
        chk(32'(stall), 32'h1);
        // errored frames kept or dropped
        for (int m = 0; m < 4; m++) begin
            wr(32'h14, 32'(m[1]) << 6);
            fr_bad <= m[0];
            pls(4'h2);
            chk(32'({keep, drop}), 32'({~(m[0] & m[1]), m[0] & m[1]}));
        end
        // eeprom timeout, long then short
        for (int s = 0; s < 2; s++) begin
            wr(32'h14, 32'(s) << 4);
            ee_wait <= 1'b1;
            wait_lvl(eto, 1'b1, 600);
            ee_wait <= 1'b0;
            chk(32'(n >= (s ? 160 : 400) && n <= (s ? 162 : 402)), 32'h1);
        end
        // lite reset restores boost, spares usb side, clears stall
        ee_pres <= 1'b1;
        img <= 2'h2;
        pls(4'h1);
        wr(32'h14, 32'h2048);
        rd(32'h14);
        chk(q, 32'h4048);
        chk(32'({dp_rst, c_rst, disc, reload, ephy_n}), 32'h11);
        wait_lvl(dp_rst, 1'b0, 300);
        rd(32'h14);
        chk(q, 32'h4040);
        chk(32'(stall), 32'h0);
        wr(32'h14, 32'h6000);
        pls(4'h8);
        chk(32'(boost), 32'h2);
        // full reset wins over lite, reloads eeprom, reconnects
        wr(32'h14, 32'h49);
        @(posedge mclk);
        #1;
        chk(32'({c_rst, ephy_n, disc, dp_rst}), 32'hB);
        wait_lvl(reload, 1'b1, 300);
        chk(32'(n < 300), 32'h1);
        img <= 2'h1;
        pls(4'h1);
        wait_lvl(disc, 1'b0, 10);
        chk(32'(disc), 32'h0);
        rd(32'h14);
        chk(q, 32'h2000);
        complete_run;
    end
endmodule // tb_hw_config_low_fields
